// ===== hw/dgpio_top.sv
// Contract
// - port a six-bit latch, reset ignores it
// - data bit six mirrors wakeup latch
// - no port function at bit six
// - port a direction one drives pin, bit two excepted
// - reset clears port a directions
// - port a read: latch or pin
// - data writes with lane zero strobe always update latch
// - port a pullup only while input
// - port a pullup enable zero disconnects
// - clock-out enable drives fast clock pin
// - clock-out ignored for crystal, external
// - port a bit two never drives
// - port b eight-bit latch, reset ignores
// - port b direction, reset clears
// - port b read: latch or pin
// - port b pullup only while input
// - direction registers read back stored
// - irq enabled reads bit two zero
`include "dgpio_cfg.svh"
`default_nettype none

module dgpio_top
    import dgpio_pkg::*;
#(
    parameter int PA_W = 6,
    parameter int PB_W = 8
) (
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi4-lite write address
    input  wire logic [11:0]       s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // axi4-lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read address
    input  wire logic [11:0]       s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // axi4-lite read data
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // system inputs
    input  wire dgpio_pkg::dgpio_osc_t osc_option,
    input  wire logic              wakeup_latch_status,
    input  wire logic              bus_clock_times_four,
    // port a pins
    input  wire logic [PA_W-1:0]   port_a_in,
    output logic [PA_W-1:0]        port_a_out,
    output logic [PA_W-1:0]        port_a_oe,
    output logic [PA_W-1:0]        port_a_pullup,
    // port b pins
    input  wire logic [PB_W-1:0]   port_b_in,
    output logic [PB_W-1:0]        port_b_out,
    output logic [PB_W-1:0]        port_b_oe,
    output logic [PB_W-1:0]        port_b_pullup
);
    import dgpio_pkg::*;

    // elaboration check: field positions assume these widths
    if (PA_W != 6 || PB_W != 8) begin : g_width_check
        $error("dgpio_top: port widths must be 6 and 8");
    end

    // the synchroniser below is built with exactly two stages
    if (`DGPIO_SYNC_STAGES != 2) begin : g_sync_check
        $error("dgpio_top: synchroniser depth must be 2");
    end

    // ************************************************************
    // register state
    // ************************************************************
    logic [PA_W-1:0] pa_latch_reg;
    logic [PA_W-1:0] pa_dir_reg;
    logic [PA_W-1:0] pa_pue_reg;
    logic [PB_W-1:0] pb_latch_reg;
    logic [PB_W-1:0] pb_dir_reg;
    logic [PB_W-1:0] pb_pue_reg;
    logic [1:0]      ctrl_reg;
    // synchroniser stages; wakeup status rides along
    logic [PA_W-1:0] pa_sync1_reg;
    logic [PA_W-1:0] pa_sync2_reg;
    logic [PB_W-1:0] pb_sync1_reg;
    logic [PB_W-1:0] pb_sync2_reg;
    logic            wake_sync1_reg;
    logic            wake_sync2_reg;

    // ************************************************************
    // axi4-lite write channel
    // ************************************************************
    logic        aw_held_reg;
    logic [11:0] aw_addr_reg;
    logic        w_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;

    // address and data may arrive in either order; hold each until both
    wire        aw_take  = s_axi_awvalid && s_axi_awready;
    wire        w_take   = s_axi_wvalid && s_axi_wready;
    wire        wr_fire  = aw_held_reg && w_held_reg && !s_axi_bvalid;
    wire [11:0] wr_addr  = aw_addr_reg;
    wire [7:0]  wr_byte  = w_data_reg[7:0];
    wire        wr_lane0 = w_strb_reg[0];

    // register decode on the held address
    wire        wr_hit_pa_data = wr_addr == `DGPIO_OFF_PA_DATA;
    wire        wr_hit_pa_dir  = wr_addr == `DGPIO_OFF_PA_DIR;
    wire        wr_hit_pa_pue  = wr_addr == `DGPIO_OFF_PA_PUE;
    wire        wr_hit_pb_data = wr_addr == `DGPIO_OFF_PB_DATA;
    wire        wr_hit_pb_dir  = wr_addr == `DGPIO_OFF_PB_DIR;
    wire        wr_hit_pb_pue  = wr_addr == `DGPIO_OFF_PB_PUE;
    wire        wr_hit_ctrl    = wr_addr == `DGPIO_OFF_CTRL;
    wire        wr_mapped = wr_hit_pa_data | wr_hit_pa_dir | wr_hit_pa_pue |
                            wr_hit_pb_data | wr_hit_pb_dir | wr_hit_pb_pue | wr_hit_ctrl;
    // lane zero gates every write; other lanes carry nothing
    wire        wr_en     = wr_fire && wr_lane0;
    wire [1:0]  wr_resp   = wr_mapped ? DGPIO_RESP_OKAY : DGPIO_RESP_SLVERR;

    // write address holding: ready is low while held, so take and fire never meet
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 12'h000;
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end else if (aw_take) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= {s_axi_awaddr[11:2], 2'b00};
        end
    end

    // write data holding: same life as the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
        end else if (w_take) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end
    end

    // ready flags: low while an item waits, so nothing is overwritten
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_reg && !aw_take && !s_axi_bvalid;
            s_axi_wready  <= !w_held_reg && !w_take && !s_axi_bvalid;
        end
    end

    // write response stands until the master takes it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_resp;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ************************************************************
    // register writes
    // ************************************************************
    // port a latch has no reset: contents survive any reset
    always_ff @(posedge aclk) begin
        if (wr_en && wr_hit_pa_data) begin
            pa_latch_reg <= wr_byte[PA_W-1:0];
        end
    end

    // port b latch, likewise kept across reset
    always_ff @(posedge aclk) begin
        if (wr_en && wr_hit_pb_data) begin
            pb_latch_reg <= wr_byte;
        end
    end

    // port a direction: every pin an input after reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pa_dir_reg <= `DGPIO_PA_DIR_RST;
        end else if (wr_en && wr_hit_pa_dir) begin
            pa_dir_reg <= wr_byte[PA_W-1:0];
        end
    end

    // port b direction: every pin an input after reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pb_dir_reg <= `DGPIO_PB_DIR_RST;
        end else if (wr_en && wr_hit_pb_dir) begin
            pb_dir_reg <= wr_byte;
        end
    end

    // port a pullup enables
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pa_pue_reg <= `DGPIO_PA_PUE_RST;
        end else if (wr_en && wr_hit_pa_pue) begin
            pa_pue_reg <= wr_byte[PA_W-1:0];
        end
    end

    // port b pullup enables
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pb_pue_reg <= `DGPIO_PB_PUE_RST;
        end else if (wr_en && wr_hit_pb_pue) begin
            pb_pue_reg <= wr_byte;
        end
    end

    // control: clock-out and irq function enables
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= `DGPIO_CTRL_RST;
        end else if (wr_en && wr_hit_ctrl) begin
            ctrl_reg <= wr_byte[1:0];
        end
    end

    // ************************************************************
    // input synchronisers
    // ************************************************************
    // first stage feeds only the second, to bound metastability
    always_ff @(posedge aclk) begin
        pa_sync1_reg   <= port_a_in;
        pa_sync2_reg   <= pa_sync1_reg;
        pb_sync1_reg   <= port_b_in;
        pb_sync2_reg   <= pb_sync1_reg;
        wake_sync1_reg <= wakeup_latch_status;
        wake_sync2_reg <= wake_sync1_reg;
    end

    // ************************************************************
    // read path
    // ************************************************************
    // input pins read the synchronised level, output pins the latch
    wire        irq_en     = ctrl_reg[`DGPIO_CTRL_IRQEN];
    wire [PA_W-1:0] pa_mix = (pa_dir_reg & pa_latch_reg) | (~pa_dir_reg & pa_sync2_reg);
    logic [PA_W-1:0] pa_view;
    always_comb begin
        pa_view = pa_mix;
        if (irq_en) pa_view[`DGPIO_PA_TWO_BIT] = 1'b0;
    end

    // read words; bit seven of port a has no source
    wire [7:0]  pa_rd = {1'b0, wake_sync2_reg, pa_view};
    wire [7:0]  pb_rd = (pb_dir_reg & pb_latch_reg) | (~pb_dir_reg & pb_sync2_reg);

    // read address decode straight off the bus
    wire [11:0] rd_addr = {s_axi_araddr[11:2], 2'b00};
    wire        rd_take = s_axi_arvalid && s_axi_arready;
    wire        rd_hit  = rd_addr == `DGPIO_OFF_PA_DATA || rd_addr == `DGPIO_OFF_PA_DIR ||
                          rd_addr == `DGPIO_OFF_PA_PUE  || rd_addr == `DGPIO_OFF_PB_DATA ||
                          rd_addr == `DGPIO_OFF_PB_DIR  || rd_addr == `DGPIO_OFF_PB_PUE ||
                          rd_addr == `DGPIO_OFF_CTRL;
    wire [1:0]  rd_resp = rd_hit ? DGPIO_RESP_OKAY : DGPIO_RESP_SLVERR;

    // read selection; unmapped offsets read zero
    logic [7:0] rd_byte;
    always_comb begin
        unique case (rd_addr)
            `DGPIO_OFF_PA_DATA: rd_byte = pa_rd;
            `DGPIO_OFF_PA_DIR:  rd_byte = {2'b00, pa_dir_reg};
            `DGPIO_OFF_PA_PUE:  rd_byte = {2'b00, pa_pue_reg};
            `DGPIO_OFF_PB_DATA: rd_byte = pb_rd;
            `DGPIO_OFF_PB_DIR:  rd_byte = pb_dir_reg;
            `DGPIO_OFF_PB_PUE:  rd_byte = pb_pue_reg;
            `DGPIO_OFF_CTRL:    rd_byte = {6'h00, ctrl_reg};
            default:            rd_byte = 8'h00;
        endcase
    end

    // read address ready: low while an answer waits, one read in flight
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !rd_take;
        end
    end

    // read answer one cycle after acceptance, held until taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'h0;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rd_byte};
            s_axi_rresp  <= rd_resp;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ************************************************************
    // pin drive
    // ************************************************************
    // clock output only for the internal and rc options
    wire osc_soft = osc_option == DGPIO_OSC_INTERNAL || osc_option == DGPIO_OSC_RC;
    wire clk_out  = ctrl_reg[`DGPIO_CTRL_CLKOUT] && osc_soft;
    logic [PA_W-1:0] pa_oe_next;
    logic [PA_W-1:0] pa_out_next;
    logic [PA_W-1:0] pa_pu_next;
    always_comb begin
        pa_oe_next  = pa_dir_reg;
        pa_out_next = pa_latch_reg;
        pa_pu_next  = pa_pue_reg & ~pa_dir_reg;
        pa_oe_next[`DGPIO_PA_TWO_BIT] = 1'b0;
        if (clk_out) begin
            // bit four becomes the clock pin; i/o and pullup yield to it
            pa_oe_next[`DGPIO_PA_FOUR_BIT]  = 1'b1;
            pa_out_next[`DGPIO_PA_FOUR_BIT] = bus_clock_times_four;
            pa_pu_next[`DGPIO_PA_FOUR_BIT]  = 1'b0;
        end
    end

    // port a pin controls; clock output lags one aclk, fine for a sampled view
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_a_oe     <= '0;
            port_a_out    <= '0;
            port_a_pullup <= '0;
        end else begin
            port_a_oe     <= pa_oe_next;
            port_a_out    <= pa_out_next;
            port_a_pullup <= pa_pu_next;
        end
    end

    // port b pin controls; pullup drops at the edge the driver turns on
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_b_oe     <= '0;
            port_b_out    <= '0;
            port_b_pullup <= '0;
        end else begin
            port_b_oe     <= pb_dir_reg;
            port_b_out    <= pb_latch_reg;
            port_b_pullup <= pb_pue_reg & ~pb_dir_reg;
        end
    end

endmodule // dgpio_top
`default_nettype wire

// ===== hw/dgpio_cfg.svh
`ifndef DGPIO_CFG_SVH
`define DGPIO_CFG_SVH

// register byte offsets on the bus
`define DGPIO_OFF_PA_DATA   12'h000
`define DGPIO_OFF_PA_DIR    12'h004
`define DGPIO_OFF_PA_PUE    12'h008
`define DGPIO_OFF_PB_DATA   12'h00c
`define DGPIO_OFF_PB_DIR    12'h010
`define DGPIO_OFF_PB_PUE    12'h014
`define DGPIO_OFF_CTRL      12'h018

// field positions
`define DGPIO_PA_WAKE_BIT   6
`define DGPIO_PA_TWO_BIT    2
`define DGPIO_PA_FOUR_BIT   4
`define DGPIO_CTRL_CLKOUT   0
`define DGPIO_CTRL_IRQEN    1

// reset values
`define DGPIO_PA_DIR_RST    6'h00
`define DGPIO_PB_DIR_RST    8'h00
`define DGPIO_PA_PUE_RST    6'h00
`define DGPIO_PB_PUE_RST    8'h00
`define DGPIO_CTRL_RST      2'h0

// synchroniser depth
`define DGPIO_SYNC_STAGES   2

`endif

// ===== hw/dgpio_pkg.sv
`default_nettype none
package dgpio_pkg;
    // oscillator option selection
    typedef enum logic [1:0] {
        DGPIO_OSC_INTERNAL = 2'b00,
        DGPIO_OSC_EXTCLK   = 2'b01,
        DGPIO_OSC_RC       = 2'b10,
        DGPIO_OSC_CRYSTAL  = 2'b11
    } dgpio_osc_t;
    // axi response codes
    typedef enum logic [1:0] {
        DGPIO_RESP_OKAY   = 2'b00,
        DGPIO_RESP_SLVERR = 2'b10
    } dgpio_resp_t;
endpackage
`default_nettype wire

// ===== bench/dgpio_board.sv
`default_nettype none
// board circuitry behind the pins
module dgpio_board #(
    parameter int W = 6
) (
    // clock for the floating pattern
    input wire logic         aclk,
    // pin controls from the block
    input wire logic [W-1:0] pin_out,
    input wire logic [W-1:0] pin_oe,
    input wire logic [W-1:0] pin_pull,
    // board driver
    input wire logic [W-1:0] ext_lvl,
    input wire logic [W-1:0] ext_en,
    // resolved pin level
    output logic [W-1:0]     pin_lvl
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [W-1:0] float_reg = '0;
    // undriven pins without pullup toggle, so a stale level never reads as a match
    always_ff @(posedge aclk) float_reg <= ~float_reg;
    // block driver wins, then board driver, then pullup
    assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_lvl)
                   | (~pin_oe & ~ext_en & (pin_pull | float_reg));
endmodule // dgpio_board
`default_nettype wire

// ===== bench/dgpio_top_sva.sv
`default_nettype none
module dgpio_top_sva #(
    parameter int PA_W = 6,
    parameter int PB_W = 8
) (
    // clock and reset
    input wire logic            aclk,
    input wire logic            aresetn,
    // bus handshakes
    input wire logic            s_axi_bvalid,
    input wire logic            s_axi_bready,
    input wire logic            s_axi_arvalid,
    input wire logic            s_axi_arready,
    input wire logic            s_axi_rvalid,
    input wire logic            s_axi_rready,
    input wire logic [31:0]     s_axi_rdata,
    // pin controls
    input wire logic [PA_W-1:0] port_a_oe,
    input wire logic [PA_W-1:0] port_a_pullup,
    input wire logic [PB_W-1:0] port_b_oe,
    input wire logic [PB_W-1:0] port_b_pullup
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // pin rules
    a_pa_two_quiet: assert property (port_a_oe[2] == 1'b0)
        else $error("port a bit two driven");
    a_pa_pull_off: assert property ((port_a_oe & port_a_pullup) == '0)
        else $error("port a pullup on a driven pin");
    a_pb_pull_off: assert property ((port_b_oe & port_b_pullup) == '0)
        else $error("port b pullup on a driven pin");
    // bus answers
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
        else $error("read data moved while waiting");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken during answer");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && !s_axi_rready);
    cover property (port_a_oe[4] && port_a_oe[0] == 1'b0);
endmodule // dgpio_top_sva
bind dgpio_top dgpio_top_sva #(.PA_W(PA_W), .PB_W(PB_W)) u_sva (.aclk, .aresetn,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .port_a_oe, .port_a_pullup, .port_b_oe, .port_b_pullup);
`default_nettype wire

// ===== bench/test_dual_gpio_port_block.sv
`include "dgpio_cfg.svh"
`default_nettype none
module test_dual_gpio_port_block
    import dgpio_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    dgpio_osc_t  osc_option;
    logic        wakeup_latch_status, bus_clock_times_four;
    logic [5:0]  port_a_in, port_a_out, port_a_oe, port_a_pullup, ext_a, ext_a_en;
    logic [7:0]  port_b_in, port_b_out, port_b_oe, port_b_pullup, ext_b, ext_b_en;
    int          err_total, checks_done, cyc;
    dgpio_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .osc_option, .wakeup_latch_status,
        .bus_clock_times_four, .port_a_in, .port_a_out, .port_a_oe, .port_a_pullup,
        .port_b_in, .port_b_out, .port_b_oe, .port_b_pullup);
    dgpio_board #(.W(6)) board_a (.aclk, .pin_out(port_a_out), .pin_oe(port_a_oe),
        .pin_pull(port_a_pullup), .ext_lvl(ext_a), .ext_en(ext_a_en), .pin_lvl(port_a_in));
    dgpio_board #(.W(8)) board_b (.aclk, .pin_out(port_b_out), .pin_oe(port_b_oe),
        .pin_pull(port_b_pullup), .ext_lvl(ext_b), .ext_en(ext_b_en), .pin_lvl(port_b_in));
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic wrap_up;
        $display("mismatches %0d comparisons %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // hang guard, the run needs a few hundred cycles
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            wrap_up();
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("FAIL %s expected %h seen %h", nm, exp, got);
            err_total++;
        end
    endtask
    // ready raised late on purpose, so the answer must stand
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic ta, tw, tb;
        logic [1:0] br;
        int n;
        @(posedge aclk);
        n = 0;
        tb = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!tb) begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid && s_axi_bready;
            br = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            s_axi_bready <= !tb && n >= 2;
            n++;
        end
        chk("bresp", 32'(DGPIO_RESP_OKAY), 32'(br));
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string nm);
        logic ta, tr;
        int n;
        @(posedge aclk);
        n = 0;
        tr = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        while (!tr) begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid && s_axi_rready;
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
            s_axi_rready <= !tr && n >= 1;
            n++;
        end
        chk(nm, exp, rd);
    endtask
    task automatic settle;
        repeat (4) @(negedge aclk);
    endtask
    task automatic t_reset_state;
        rchk(`DGPIO_OFF_PA_DIR, 32'h0, "dir_a");
        rchk(`DGPIO_OFF_PB_DIR, 32'h0, "dir_b");
        chk("oe_a", 32'h0, 32'(port_a_oe));
        rchk(12'h100, 32'h0, "unmapped");
        chk("unmapped_resp", 32'(rsp), 32'(DGPIO_RESP_SLVERR));
    endtask
    task automatic t_port_a;
        wr(`DGPIO_OFF_PA_PUE, 8'h3f);
        wr(`DGPIO_OFF_PA_DATA, 8'h2d);
        wr(`DGPIO_OFF_PA_DIR, 8'h0f);
        settle();
        chk("oe_a", 32'h0b, 32'(port_a_oe));
        chk("out_a", 32'h09, 32'(port_a_out & 6'h0b));
        chk("pull_a", 32'h30, 32'(port_a_pullup));
        rchk(`DGPIO_OFF_PA_DATA, 32'h3d, "data_a");
        wakeup_latch_status <= 1'b1;
        settle();
        rchk(`DGPIO_OFF_PA_DATA, 32'h7d, "wake_a");
        wr(`DGPIO_OFF_PA_PUE, 8'h00);
        wr(`DGPIO_OFF_PA_DIR, 8'h00);
        ext_a <= 6'h15;
        ext_a_en <= 6'h3f;
        settle();
        chk("pull_off_a", 32'h0, 32'(port_a_pullup));
        rchk(`DGPIO_OFF_PA_DATA, 32'h55, "pins_a");
        wr(`DGPIO_OFF_PA_DATA, 8'h2a);
        rchk(`DGPIO_OFF_PA_DATA, 32'h55, "in_write_a");
        wr(`DGPIO_OFF_PA_DIR, 8'hff);
        rchk(`DGPIO_OFF_PA_DATA, 32'h6a, "latch_a");
        rchk(`DGPIO_OFF_PA_DIR, 32'h3f, "dir_back_a");
        wakeup_latch_status <= 1'b0;
        wr(`DGPIO_OFF_PA_DIR, 8'h00);
        ext_a <= 6'h3f;
        wr(`DGPIO_OFF_CTRL, 8'h02);
        rchk(`DGPIO_OFF_PA_DATA, 32'h3b, "irq_a");
        wr(`DGPIO_OFF_CTRL, 8'h00);
        rchk(`DGPIO_OFF_PA_DATA, 32'h3f, "no_irq_a");
    endtask
    // clock output only for internal and resistor-capacitor options
    task automatic t_clock_out;
        ext_a_en <= 6'h00;
        bus_clock_times_four <= 1'b1;
        wr(`DGPIO_OFF_CTRL, 8'h01);
        for (int i = 0; i < 4; i++) begin
            @(posedge aclk);
            osc_option <= dgpio_osc_t'(i);
            settle();
            chk("clk_oe", 32'(i == 0 || i == 2), 32'(port_a_oe[4]));
            if (i == 0 || i == 2) chk("clk_out", 32'h1, 32'(port_a_out[4]));
        end
        wr(`DGPIO_OFF_CTRL, 8'h00);
    endtask
    task automatic t_port_b;
        wr(`DGPIO_OFF_PB_DATA, 8'ha5);
        wr(`DGPIO_OFF_PB_DIR, 8'hf0);
        wr(`DGPIO_OFF_PB_PUE, 8'hff);
        ext_b <= 8'h04;
        ext_b_en <= 8'h0c;
        settle();
        chk("oe_b", 32'hf0, 32'(port_b_oe));
        chk("out_b", 32'ha0, 32'(port_b_out & 8'hf0));
        chk("pull_b", 32'h0f, 32'(port_b_pullup));
        rchk(`DGPIO_OFF_PB_DATA, 32'ha7, "data_b");
        rchk(`DGPIO_OFF_PB_DIR, 32'hf0, "dir_back_b");
        aresetn <= 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(`DGPIO_OFF_PB_DIR, 32'h0, "dir_b_rst");
        wr(`DGPIO_OFF_PB_DIR, 8'hff);
        wr(`DGPIO_OFF_PA_DIR, 8'h3f);
        rchk(`DGPIO_OFF_PB_DATA, 32'ha5, "keep_b");
        rchk(`DGPIO_OFF_PA_DATA, 32'h2a, "keep_a");
    endtask
    initial begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {wakeup_latch_status, bus_clock_times_four, ext_a, ext_a_en, ext_b, ext_b_en} = '0;
        osc_option = DGPIO_OSC_INTERNAL;
        err_total = 0;
        checks_done = 0;
        cyc = 0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset_state();
        t_port_a();
        t_clock_out();
        t_port_b();
        wrap_up();
    end
endmodule // test_dual_gpio_port_block
`default_nettype wire
